// ==== mavf_pkg.sv ====
// mavf_pkg: constants and types for the moving-average reading filter
// assumes a single 200 MHz clock domain
package mavf_pkg;
  localparam int RD_W = 24;
  localparam int DEPTH_MAX = 100;
  localparam int DEPTH_MIN = 2;
  localparam int DEPTH_W = 7;
  localparam int FUNC_W = 2;
  localparam int NFUNC = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SUM_W = RD_W + DEPTH_W;
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 7'h0A;
  localparam logic [2:0] DIG_RST = 3'h6;
  localparam logic [2:0] DIG_MIN = 3'h4;
  localparam logic [2:0] DIG_MAX = 3'h6;
  // register map: one word per setting, four per function, index * 16 per function block
  localparam logic [ADDR_W-1:0] REG_DEPTH = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] REG_WIN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DIG = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h34;
  localparam logic [ADDR_W-1:0] FUNC_STRIDE = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TYPE_BIT = 1;
  typedef enum logic [FUNC_W-1:0] {
    MAVF_FN_CONC = 2'b00,
    MAVF_FN_CURR = 2'b01,
    MAVF_FN_VOLT = 2'b10
  } mavf_func_t;
  typedef enum logic {
    MAVF_TYPE_MOVING = 1'b0
  } mavf_type_t;
  // window steps, percent codes: 0.01, 0.1, 1, 10, 100
  typedef enum logic [2:0] {
    MAVF_WIN_P01 = 3'b000,
    MAVF_WIN_P1 = 3'b001,
    MAVF_WIN_1 = 3'b010,
    MAVF_WIN_10 = 3'b011,
    MAVF_WIN_100 = 3'b100
  } mavf_win_t;
  localparam mavf_win_t WIN_RST = MAVF_WIN_1;
  typedef enum logic [1:0] {
    MAVF_ST_EMPTY = 2'b00,
    MAVF_ST_FILL = 2'b01,
    MAVF_ST_RUN = 2'b10
  } mavf_state_t;
endpackage

// ==== mavf_hist_mem.sv ====
// mavf_hist_mem: history memory for filter readings, registered read
// assumes one write and one read port on the same clock
`timescale 1ns/1ps
module mavf_hist_mem #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 300,
  parameter int AW = 9
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata_q <= mem[raddr];
  end
endmodule

// ==== mavf_filter.sv ====
// mavf_filter: per-function moving-average filter of converter readings
// assumes readings arrive as one-cycle strobes, at least depth+3 cycles apart
// Functional notes
// - depth writes of 2 to 100 accepted, others rejected and flagged
// - reset puts depth of every function at 10
// - history ring wraps at exactly the current depth
// - enable bit 0 off, 1 on; on after reset
// - enabled output is the mean of the stored readings
// - moving average is the only type and the default
// - each new reading enters the ring first-in first-out
// - new reading overwrites the oldest slot, occupancy equals depth
// - one result per reading, averaged when enabled, raw when disabled
// - first reading after restart is copied into every slot
// - settled flag rises once depth-1 real readings replaced the fill; raw results of a disabled function are always settled
// - window codes restricted to five steps 0.01 to 100 percent
// - window values between steps round up to the next step
// - reset puts window at 1 percent
// - depth, enable, window, digits held separately per function
// - digits setting per function, 6 after reset
// - digits change applies at next completed reading, not remote data
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mavf_filter
  import mavf_pkg::*;
#(
  parameter int RDW = mavf_pkg::RD_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [mavf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mavf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mavf_pkg::DATA_W-1:0] reg_rdata_q,
  input wire logic [mavf_pkg::FUNC_W-1:0] func_sel,
  input wire logic rd_valid,
  input wire logic [mavf_pkg::RD_W-1:0] rd_data,
  output logic out_valid_q,
  output logic [mavf_pkg::RD_W-1:0] out_data_q,
  output logic out_settled_q,
  output logic [2:0] disp_digits_q,
  output logic cfg_err_q
);
  import mavf_pkg::*;

  localparam int AW = 9;
  localparam int MEMD = NFUNC * DEPTH_MAX;

  ////////////////////////////////////////////////////////////////////////
  // per-function settings
  logic [DEPTH_W-1:0] depth_q [NFUNC];
  logic en_q [NFUNC];
  mavf_win_t win_q [NFUNC];
  logic [2:0] dig_q [NFUNC];
  logic [1:0] fsel;
  logic [3:0] fword;
  logic hit_fn;
  assign fsel = reg_addr[5:4];
  assign fword = reg_addr[3:0];
  assign hit_fn = (reg_addr < REG_STAT) && (reg_addr[1:0] == 2'b00);

  function automatic mavf_win_t win_round(input logic [DATA_W-1:0] v);
    // value in hundredths of a percent, rounded up to a step
    if (v <= 32'h0000_0001) begin
      win_round = MAVF_WIN_P01;
    end else if (v <= 32'h0000_000A) begin
      win_round = MAVF_WIN_P1;
    end else if (v <= 32'h0000_0064) begin
      win_round = MAVF_WIN_1;
    end else if (v <= 32'h0000_03E8) begin
      win_round = MAVF_WIN_10;
    end else begin
      win_round = MAVF_WIN_100;
    end
  endfunction

  logic win_ok;
  logic depth_ok;
  logic dig_ok;
  assign win_ok = (reg_wdata != 32'h0) && (reg_wdata <= 32'h0000_2710);
  assign depth_ok = (reg_wdata >= DEPTH_MIN) && (reg_wdata <= DEPTH_MAX);
  assign dig_ok = (reg_wdata >= 32'(DIG_MIN)) && (reg_wdata <= 32'(DIG_MAX));

  logic [NFUNC-1:0] depth_wr;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NFUNC; i++) begin
        depth_q[i] <= DEPTH_RST;
        en_q[i] <= 1'b1;
        win_q[i] <= WIN_RST;
        dig_q[i] <= DIG_RST;
      end
      depth_wr <= '0;
    end else begin
      depth_wr <= '0;
      if (reg_wr && hit_fn && fsel < 2'(NFUNC)) begin
        if (fword == REG_DEPTH[3:0] && depth_ok) begin
          depth_q[fsel] <= reg_wdata[DEPTH_W-1:0];
          depth_wr[fsel] <= 1'b1;
        end else if (fword == REG_CTRL[3:0]) begin
          en_q[fsel] <= reg_wdata[CTRL_EN_BIT];
        end else if (fword == REG_WIN[3:0] && win_ok) begin
          win_q[fsel] <= win_round(reg_wdata);
        end else if (fword == REG_DIG[3:0] && dig_ok) begin
          dig_q[fsel] <= reg_wdata[2:0];
        end
      end
    end
  end

  // bad value written to depth, window, digits or ctrl type
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_err_q <= 1'b0;
    end else if (reg_wr && hit_fn && fsel < 2'(NFUNC)) begin
      if (fword == REG_DEPTH[3:0]) begin
        cfg_err_q <= !depth_ok;
      end else if (fword == REG_WIN[3:0]) begin
        cfg_err_q <= !win_ok;
      end else if (fword == REG_DIG[3:0]) begin
        cfg_err_q <= !dig_ok;
      end else begin
        cfg_err_q <= reg_wdata[CTRL_TYPE_BIT] != MAVF_TYPE_MOVING;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // filter datapath
  mavf_state_t st_q [NFUNC];
  logic [DEPTH_W-1:0] wptr_q;
  logic [DEPTH_W-1:0] fcnt_q;
  logic [DEPTH_W-1:0] fresh_q [NFUNC];
  logic [DEPTH_W-1:0] head_q [NFUNC];
  logic [SUM_W-1:0] sum_q [NFUNC];
  logic [FUNC_W-1:0] fn_q;
  logic [RDW-1:0] new_q;
  logic busy_q;
  logic upd_q;
  logic [AW-1:0] waddr;
  logic [AW-1:0] raddr;
  logic we;
  logic [RDW-1:0] old_rd;
  logic [DEPTH_W-1:0] cur_depth;
  logic [SUM_W-1:0] avg_full;
  logic [RDW-1:0] avg_now;
  logic [RDW:0] diff;
  logic [RDW+6:0] thr;
  logic outside;

  assign cur_depth = depth_q[fn_q];
  assign avg_full = sum_q[fn_q] / SUM_W'(cur_depth);
  assign avg_now = avg_full[RDW-1:0];
  assign diff = (new_q > avg_now) ? {1'b0, new_q - avg_now} : {1'b0, avg_now - new_q};
  always_comb begin
    case (win_q[fn_q])
      MAVF_WIN_P01: thr = (RDW+7)'(avg_now) / (RDW+7)'(10000);
      MAVF_WIN_P1: thr = (RDW+7)'(avg_now) / (RDW+7)'(1000);
      MAVF_WIN_1: thr = (RDW+7)'(avg_now) / (RDW+7)'(100);
      MAVF_WIN_10: thr = (RDW+7)'(avg_now) / (RDW+7)'(10);
      default: thr = (RDW+7)'(avg_now);
    endcase
  end
  assign outside = (RDW+7)'(diff) > thr;

  // slot index per function lives at base fn*DEPTH_MAX
  // read ahead at the take edge, so the oldest slot stands in the update cycle
  logic take;
  logic [FUNC_W-1:0] rfn;
  assign rfn = take ? func_sel : fn_q;
  assign raddr = AW'(rfn * DEPTH_MAX) + AW'(head_q[rfn]);
  assign waddr = busy_q ? AW'(fn_q * DEPTH_MAX) + AW'(wptr_q) : raddr;
  assign we = busy_q || upd_q;

  mavf_hist_mem #(.WIDTH(RDW), .DEPTH(MEMD), .AW(AW)) u_hist (
    .core_clk(core_clk),
    .we(we),
    .waddr(waddr),
    .wdata(new_q),
    .raddr(raddr),
    .rdata_q(old_rd)
  );

  assign take = rd_valid && !busy_q && !upd_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NFUNC; i++) begin
        st_q[i] <= MAVF_ST_EMPTY;
        fresh_q[i] <= '0;
        head_q[i] <= '0;
        sum_q[i] <= '0;
      end
      fn_q <= '0;
      new_q <= '0;
      busy_q <= 1'b0;
      upd_q <= 1'b0;
      wptr_q <= '0;
      fcnt_q <= '0;
    end else begin
      for (int i = 0; i < NFUNC; i++) begin
        if (depth_wr[i]) begin
          st_q[i] <= MAVF_ST_EMPTY;
        end
      end
      upd_q <= 1'b0;
      if (take) begin
        fn_q <= func_sel;
        new_q <= rd_data;
        if (!en_q[func_sel]) begin
          upd_q <= 1'b0;
        end else begin
          upd_q <= 1'b1;
        end
      end
      if (upd_q) begin
        case (st_q[fn_q])
          MAVF_ST_EMPTY: begin
            busy_q <= 1'b1;
            wptr_q <= '0;
            fcnt_q <= cur_depth;
            st_q[fn_q] <= MAVF_ST_FILL;
          end
          default: begin
            if (outside) begin
              busy_q <= 1'b1;
              wptr_q <= '0;
              fcnt_q <= cur_depth;
              st_q[fn_q] <= MAVF_ST_FILL;
            end else begin
              // replace oldest, ring wraps at depth
              sum_q[fn_q] <= sum_q[fn_q] - SUM_W'(old_rd) + SUM_W'(new_q);
              head_q[fn_q] <= (head_q[fn_q] == cur_depth - 7'h01) ? '0 :
                              head_q[fn_q] + 7'h01;
              if (fresh_q[fn_q] != cur_depth) begin
                fresh_q[fn_q] <= fresh_q[fn_q] + 7'h01;
              end
              st_q[fn_q] <= MAVF_ST_RUN;
            end
          end
        endcase
      end
      if (busy_q) begin
        wptr_q <= wptr_q + 7'h01;
        fcnt_q <= fcnt_q - 7'h01;
        if (fcnt_q == 7'h01) begin
          busy_q <= 1'b0;
          sum_q[fn_q] <= SUM_W'(new_q) * SUM_W'(cur_depth);
          head_q[fn_q] <= 7'h01 == cur_depth ? '0 : 7'h01;
          fresh_q[fn_q] <= 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result outputs
  logic fin;
  assign fin = (busy_q && fcnt_q == 7'h01) || (upd_q && st_q[fn_q] != MAVF_ST_EMPTY && !outside);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      out_settled_q <= 1'b0;
      disp_digits_q <= DIG_RST;
    end else begin
      out_valid_q <= 1'b0;
      if (take && !en_q[func_sel]) begin
        out_valid_q <= 1'b1;
        out_data_q <= rd_data;
        out_settled_q <= 1'b1;
        disp_digits_q <= dig_q[func_sel];
      end else if (fin) begin
        out_valid_q <= 1'b1;
        disp_digits_q <= dig_q[fn_q];
        if (busy_q) begin
          out_data_q <= new_q;
          out_settled_q <= (cur_depth == 7'h01);
        end else begin
          out_data_q <= RDW'((sum_q[fn_q] - SUM_W'(old_rd) + SUM_W'(new_q))
                              / SUM_W'(cur_depth));
          out_settled_q <= (fresh_q[fn_q] + 7'h01 >= cur_depth);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      if (hit_fn && fsel < 2'(NFUNC) && fword == REG_DEPTH[3:0]) begin
        reg_rdata_q <= DATA_W'(depth_q[fsel]);
      end else if (hit_fn && fsel < 2'(NFUNC) && fword == REG_CTRL[3:0]) begin
        reg_rdata_q <= DATA_W'(en_q[fsel]);
      end else if (hit_fn && fsel < 2'(NFUNC) && fword == REG_WIN[3:0]) begin
        reg_rdata_q <= DATA_W'(win_q[fsel]);
      end else if (hit_fn && fsel < 2'(NFUNC) && fword == REG_DIG[3:0]) begin
        reg_rdata_q <= DATA_W'(dig_q[fsel]);
      end else if (reg_addr == REG_STAT) begin
        reg_rdata_q <= {26'h0, st_q[2], st_q[1], st_q[0]};
      end else if (reg_addr == REG_ACTIVE) begin
        reg_rdata_q <= {22'h0, busy_q, fresh_q[fn_q], fn_q};
      end else begin
        reg_rdata_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_depth_range: assert property (@(posedge core_clk) disable iff (!nrst)
    depth_q[0] >= DEPTH_MIN && depth_q[0] <= DEPTH_MAX)
    else $error("depth out of range");
  a_depth_reject: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && hit_fn && fsel == 2'b00 && fword == 4'h0 && !depth_ok |=>
    $stable(depth_q[0]) && cfg_err_q)
    else $error("bad depth not rejected");
  a_win_round: assert property (@(posedge core_clk) disable iff (!nrst)
    reg_wr && reg_addr == REG_WIN + FUNC_STRIDE && reg_wdata == 32'h0000_0032 |=>
    win_q[1] == MAVF_WIN_1)
    else $error("window not rounded up");
  a_one_result: assert property (@(posedge core_clk) disable iff (!nrst)
    upd_q && st_q[fn_q] == MAVF_ST_RUN && !outside |=> out_valid_q)
    else $error("missing averaged result");
  a_fill_len: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(busy_q) |-> ##[1:100] !busy_q)
    else $error("fill too long");
  a_raw_off: assert property (@(posedge core_clk) disable iff (!nrst)
    take && !en_q[func_sel] |=> out_valid_q && out_data_q == $past(rd_data))
    else $error("raw pass when disabled");
  a_not_settled: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy_q) && cur_depth > 7'h01 |-> out_valid_q && !out_settled_q)
    else $error("fill result marked settled");
  a_digits_upd: assert property (@(posedge core_clk) disable iff (!nrst)
    fin && !(take && !en_q[func_sel]) |=> disp_digits_q == $past(dig_q[fn_q]))
    else $error("digits not applied");
  a_head_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
    head_q[0] < depth_q[0] || st_q[0] == MAVF_ST_EMPTY || depth_wr[0])
    else $error("ring past depth");
  c_fill: cover property (@(posedge core_clk) disable iff (!nrst) $fell(busy_q));
  c_settle: cover property (@(posedge core_clk) disable iff (!nrst) $rose(out_settled_q));
  c_refill: cover property (@(posedge core_clk) disable iff (!nrst)
    upd_q && st_q[fn_q] != MAVF_ST_EMPTY && outside);
endmodule

// ==== mavf_conv_model.sv ====
// mavf_conv_model: converter model issuing one-cycle reading strobes
// assumes the bench spaces its requests as the filter requires
`timescale 1ns/1ps
module mavf_conv_model
  import mavf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic req,
  input wire logic [mavf_pkg::FUNC_W-1:0] req_func,
  input wire logic [mavf_pkg::RD_W-1:0] req_data,
  output logic rd_valid,
  output logic [mavf_pkg::FUNC_W-1:0] func_sel,
  output logic [mavf_pkg::RD_W-1:0] rd_data
);
  import mavf_pkg::*;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      func_sel <= '0;
      rd_data <= '0;
    end else if (req) begin
      rd_valid <= 1'b1;
      func_sel <= req_func;
      rd_data <= req_data;
    end else begin
      // stale lines toggle so no old value survives outside a strobe
      rd_valid <= 1'b0;
      func_sel <= ~func_sel;
      rd_data <= ~rd_data;
    end
  end
endmodule

// ==== testbench.sv ====
// testbench: register and reading sequences for the moving-average filter
// assumes mavf_pkg, mavf_filter and mavf_conv_model are compiled first
`timescale 1ns/1ps
module testbench;
  import mavf_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, req, rd_valid;
  logic out_valid_q, out_settled_q, cfg_err_q, os;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata_q, v;
  logic [FUNC_W-1:0] func_sel, req_func;
  logic [RD_W-1:0] rd_data, req_data, out_data_q, od;
  logic [2:0] disp_digits_q, dd;
  int mismatches, compares;
  int dv[4] = '{1, 101, 2, 100};
  int dr[4] = '{10, 10, 2, 100};
  int wv[9] = '{1, 10, 50, 100, 1000, 9999, 10000, 0, 10001};
  int wc[9] = '{0, 1, 2, 2, 3, 4, 4, 4, 4};
  int mv[5] = '{100, 200, 200, 200, 200};
  int ma[5] = '{100, 125, 150, 175, 200};

  mavf_filter i_mavf_filter (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .func_sel(func_sel), .rd_valid(rd_valid), .rd_data(rd_data),
    .out_valid_q(out_valid_q), .out_data_q(out_data_q), .out_settled_q(out_settled_q),
    .disp_digits_q(disp_digits_q), .cfg_err_q(cfg_err_q));
  mavf_conv_model i_mavf_conv_model (.core_clk(core_clk), .nrst(nrst), .req(req),
    .req_func(req_func), .req_data(req_data), .rd_valid(rd_valid),
    .func_sel(func_sel), .rd_data(rd_data));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] fa(input int f, input logic [7:0] o);
    return FUNC_STRIDE * 8'(f) + o;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    reg_addr <= a;
    reg_wdata <= 32'(d);
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata_q;
  endtask

  // one reading; result captured in the cycle of its pulse
  task automatic meas(input int f, input int d);
    int n;
    req_func <= FUNC_W'(f);
    req_data <= RD_W'(d);
    req <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    n = 0;
    while (out_valid_q !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    od = out_data_q;
    os = out_settled_q;
    dd = disp_digits_q;
    if (n >= 300) begin
      mismatches++;
      $display("wrong value at %0t: no result", $time);
    end
    repeat (12) @(posedge core_clk);
  endtask

  task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    finish_test;
  end

  initial begin
    mismatches = 0;
    compares = 0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    req = 1'b0;
    req_func = '0;
    req_data = '0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    chk(32'(disp_digits_q), 32'h6);
    for (int f = 0; f < NFUNC; f++) begin
      rd(fa(f, REG_DEPTH));
      chk(v, 32'h0A);
      rd(fa(f, REG_CTRL));
      chk(v, 32'h01);
      rd(fa(f, REG_WIN));
      chk(v, 32'h02);
      rd(fa(f, REG_DIG));
      chk(v, 32'h06);
    end
    rd(8'h3C);
    chk(v, 32'h00);
    for (int i = 0; i < 4; i++) begin
      wr(fa(0, REG_DEPTH), dv[i]);
      chk(32'(cfg_err_q), 32'(i < 2));
      rd(fa(0, REG_DEPTH));
      chk(v, 32'(dr[i]));
    end
    for (int i = 0; i < 9; i++) begin
      wr(fa(1, REG_WIN), wv[i]);
      chk(32'(cfg_err_q), 32'(i > 6));
      rd(fa(1, REG_WIN));
      chk(v, 32'(wc[i]));
    end
    wr(fa(1, REG_DIG), 5);
    wr(fa(1, REG_DIG), 7);
    chk(32'(cfg_err_q), 32'h1);
    rd(fa(1, REG_DIG));
    chk(v, 32'h05);
    rd(fa(0, REG_DIG));
    chk(v, 32'h06);
    rd(fa(1, REG_DEPTH));
    chk(v, 32'h0A);
    wr(fa(1, REG_CTRL), 3);
    chk(32'(cfg_err_q), 32'h1);
    wr(fa(1, REG_CTRL), 0);
    meas(1, 77);
    chk(32'(od), 32'h4D);
    chk(32'(dd), 32'h5);
    chk(32'(os), 32'h1);
    wr(fa(0, REG_DEPTH), 4);
    wr(fa(0, REG_WIN), 10000);
    for (int i = 0; i < 5; i++) begin
      meas(0, mv[i]);
      chk(32'(od), 32'(ma[i]));
      chk(32'(os), 32'(i > 2));
    end
    wr(fa(0, REG_DIG), 4);
    meas(0, 400);
    chk(32'(od), 32'hFA);
    chk(32'(dd), 32'h4);
    wr(fa(2, REG_DEPTH), 2);
    wr(fa(2, REG_WIN), 1);
    meas(2, 1000);
    meas(2, 1001);
    chk(32'(od), 32'h3E9);
    chk(32'(os), 32'h0);
    rd(REG_STAT);
    chk(v, 32'h12);
    rd(REG_ACTIVE);
    chk(v, 32'h06);
    finish_test;
  end
endmodule
